// [logic/isp_pkg.sv]
// package for the interrupt software priority block: register map,
// reset values, priority encodings and bus carrier types.
// assumes a 32-bit AXI4-Lite register bus and a 14-vector controller.
package isp_pkg;

    // register byte offsets on the register bus
    localparam logic [7:0] ISP_OFS_BANK0  = 8'h00;
    localparam logic [7:0] ISP_OFS_BANK1  = 8'h04;
    localparam logic [7:0] ISP_OFS_BANK2  = 8'h08;
    localparam logic [7:0] ISP_OFS_BANK3  = 8'h0C;
    localparam logic [7:0] ISP_OFS_COND   = 8'h10;
    localparam logic [7:0] ISP_OFS_STATUS = 8'h14;

    // condition register layout
    localparam int ISP_CC_HI_POS = 5;
    localparam int ISP_CC_LO_POS = 3;
    localparam int ISP_CC_H_POS  = 4;

    // reset values (half-carry bit taken as zero)
    localparam logic [7:0] ISP_CC_RESET   = 8'hEA;
    localparam logic [7:0] ISP_BANK_RESET = 8'hFF;
    localparam logic [3:0] ISP_BANK3_TOP  = 4'hF;

    // vector count and field geometry
    localparam int ISP_NVEC     = 14;
    localparam int ISP_TLI_VEC  = 0;
    localparam int ISP_VEC_BITS = 4;

    // {high bit, low bit} codes of the four levels
    localparam logic [1:0] ISP_CODE_L0 = 2'h2;
    localparam logic [1:0] ISP_CODE_L1 = 2'h1;
    localparam logic [1:0] ISP_CODE_L2 = 2'h0;
    localparam logic [1:0] ISP_CODE_L3 = 2'h3;

    // axi response codes
    localparam logic [1:0] ISP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ISP_RESP_SLVERR = 2'h2;

    // cpu-side request to the priority logic
    typedef struct packed {
        logic       enable_irq;    // enable-interrupts instruction
        logic       disable_irq;   // disable, halt or wait-for-irq
        logic       restore;       // return or pop of the condition reg
        logic [7:0] restore_val;   // value restored
        logic       entry_ack;     // cpu takes the offered vector
    } isp_cpu_req_t;

    // answer toward the cpu sequencer
    typedef struct packed {
        logic       take;          // a vector is offered
        logic [3:0] vec;           // index of the maskable vector
        logic       nmi;           // offered entry is non-maskable
    } isp_cpu_ans_t;

endpackage

// [logic/isp_priority.sv]
// interrupt software priority logic: current level in the condition
// register, four per-vector priority banks and maskable arbitration.
// assumes a cpu sequencer on REF_CLK and pending requests synchronous
// to REF_CLK; registers reached over AXI4-Lite.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - the current level is held in condition bits 5 (high) and 3 (low).
// - codes hi/lo 10 is level 0, 01 level 1, 00 level 2, 11 level 3.
// - reset leaves the condition register at 111x 1010.
// - on interrupt entry the level takes the vector's programmed code.
// - enable, disable, halt, wait, return and pop also set the level.
// - non-maskable requests are taken even at level 3.
// - four readable and writable banks reset to all ones.
// - bits 7 to 4 of the fourth bank read as one and ignore writes.
// - fields 0 to 13 map to vectors in order, lowest index in bits 1:0.
// - a field written with the level-0 code keeps its old value.
// - non-maskable entries set both current level bits to one.
// - the top-level interrupt field is storage only, not arbitrated.
// - a changed field re-enters a still pending vector if now higher.
module isp_priority
    import isp_pkg::*;
(
    // clock, reset, enable
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    // axi4-lite write channels
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // axi4-lite read channels
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // cpu sequencer side
    input  isp_cpu_req_t     CPU_REQ,
    output isp_cpu_ans_t     CPU_ANS,
    output logic [7:0]       COND_OUT,
    // interrupt sources
    input  wire logic [13:0] IRQ_PEND,
    input  wire logic        NMI_REQ
);

    logic [7:0]  cc_reg;
    logic [7:0]  bank_reg [4];
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_ok;
    logic        win_any;
    logic [3:0]  win_vec;
    logic [1:0]  win_code;
    logic [2:0]  cur_rank;
    logic [1:0]  entry_code;
    logic        entry_nmi;

    // rank of a two-bit code, higher rank is higher priority
    function automatic logic [2:0] rank(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h0;
        case (code)
            ISP_CODE_L0: r = 3'h0;
            ISP_CODE_L1: r = 3'h1;
            ISP_CODE_L2: r = 3'h2;
            default:     r = 3'h3;
        endcase
        return r;
    endfunction

    // one field write: the level-0 pattern is refused per field
    function automatic logic [1:0] fld_wr(input logic [1:0] old_v,
                                           input logic [1:0] new_v);
        logic [1:0] r;
        r = (new_v == ISP_CODE_L0) ? old_v : new_v;
        return r;
    endfunction

    // ------------------------------------------------------------
    // write channel: address and data latched in either order
    assign wr_fire = aw_hold_reg && w_hold_reg && !BVALID;
    assign wr_ok   = (awaddr_reg[7:2] <= ISP_OFS_STATUS[7:2])
                     && (awaddr_reg[1:0] == 2'h0);

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            AWREADY     <= 1'b0;
            WREADY      <= 1'b0;
            BVALID      <= 1'b0;
            BRESP       <= ISP_RESP_OKAY;
        end
        else if (CLK_EN)
        begin
            // ready pulses for one cycle on acceptance
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
            if (AWVALID && !aw_hold_reg && !AWREADY)
            begin
                AWREADY     <= 1'b1;
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= AWADDR;
            end
            if (WVALID && !w_hold_reg && !WREADY)
            begin
                WREADY     <= 1'b1;
                w_hold_reg <= 1'b1;
                wdata_reg  <= WDATA;
                wstrb_reg  <= WSTRB;
            end
            if (wr_fire)
            begin
                BVALID      <= 1'b1;
                BRESP       <= wr_ok ? ISP_RESP_OKAY : ISP_RESP_SLVERR;
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
            end
            else if (BVALID && BREADY)
            begin
                BVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // priority banks; only byte lane 0 carries data
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            for (int b = 0; b < 4; b++)
                bank_reg[b] <= ISP_BANK_RESET;
        end
        else if (CLK_EN && wr_fire && wstrb_reg[0]
                 && awaddr_reg[7:4] == 4'h0 && awaddr_reg[1:0] == 2'h0)
        begin
            for (int f = 0; f < 4; f++)
                bank_reg[awaddr_reg[3:2]][2*f +: 2] <=
                    fld_wr(bank_reg[awaddr_reg[3:2]][2*f +: 2],
                           wdata_reg[2*f +: 2]);
            if (awaddr_reg[3:2] == 2'h3)
                bank_reg[3][7:4] <= ISP_BANK3_TOP;
        end
    end

    // ------------------------------------------------------------
    // read channel, one read at a time
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= ISP_RESP_OKAY;
        end
        else if (CLK_EN)
        begin
            ARREADY <= 1'b0;
            if (rd_fire)
                ARREADY <= 1'b1;
            // answer one cycle after the address handshake: the bus
            // forbids read data before the address has been taken
            if (ARREADY && ARVALID)
            begin
                RVALID  <= 1'b1;
                RRESP   <= ISP_RESP_OKAY;
                if (ARADDR[1:0] != 2'h0)
                begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= ISP_RESP_SLVERR;
                end
                else if (ARADDR[7:2] < 6'h4)
                    RDATA <= {24'h0, bank_reg[ARADDR[3:2]]};
                else if (ARADDR == ISP_OFS_COND)
                    RDATA <= {24'h0, cc_reg};
                else if (ARADDR == ISP_OFS_STATUS)
                    RDATA <= {23'h0, win_any, win_vec, 2'h0, win_code};
                else
                begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= ISP_RESP_SLVERR;
                end
            end
            else if (RVALID && RREADY)
            begin
                RVALID <= 1'b0;
            end
        end
    end
    assign rd_fire = ARVALID && !RVALID && !ARREADY;

    // ------------------------------------------------------------
    // arbitration: scan low to high; the strict compare keeps the
    // lowest index, which is the highest vector address, on ties
    assign cur_rank = rank({cc_reg[ISP_CC_HI_POS], cc_reg[ISP_CC_LO_POS]});

    always_comb
    begin
        logic [1:0] code;
        code     = 2'h0;
        win_any  = 1'b0;
        win_vec  = 4'h0;
        win_code = ISP_CODE_L0;
        // field 0 belongs to the top-level line and never arbitrates
        for (int v = ISP_TLI_VEC + 1; v < ISP_NVEC; v++)
        begin
            code = bank_reg[v / 4][2*(v % 4) +: 2];
            // live field value: a raised field re-enters
            if (IRQ_PEND[v] && rank(code) > cur_rank
                && (!win_any || rank(code) > rank(win_code)))
            begin
                win_any  = 1'b1;
                win_vec  = v[3:0];
                win_code = code;
            end
        end
    end

    // non-maskable entry ignores the level
    assign entry_nmi  = NMI_REQ;
    assign entry_code = entry_nmi ? ISP_CODE_L3 : win_code;

    // offer toward the cpu, registered
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            CPU_ANS <= '0;
        else if (CLK_EN)
        begin
            CPU_ANS.take <= entry_nmi || win_any;
            CPU_ANS.vec  <= win_vec;
            CPU_ANS.nmi  <= entry_nmi;
        end
    end

    // ------------------------------------------------------------
    // condition register and its level bits
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            cc_reg <= ISP_CC_RESET;
        else if (CLK_EN)
        begin
            if (CPU_REQ.entry_ack && (entry_nmi || win_any))
            begin
                cc_reg[ISP_CC_HI_POS] <= entry_code[1];
                cc_reg[ISP_CC_LO_POS] <= entry_code[0];
            end
            else if (CPU_REQ.restore)
                cc_reg <= {2'h3, CPU_REQ.restore_val[5:0]};
            else if (CPU_REQ.disable_irq)
            begin
                cc_reg[ISP_CC_HI_POS] <= ISP_CODE_L3[1];
                cc_reg[ISP_CC_LO_POS] <= ISP_CODE_L3[0];
            end
            else if (CPU_REQ.enable_irq)
            begin
                cc_reg[ISP_CC_HI_POS] <= ISP_CODE_L0[1];
                cc_reg[ISP_CC_LO_POS] <= ISP_CODE_L0[0];
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            COND_OUT <= ISP_CC_RESET;
        else if (CLK_EN)
            COND_OUT <= cc_reg;
    end

    // ------------------------------------------------------------
    // checks
    AST_RESET_CC: assert property (@(posedge REF_CLK)
        $fell(SYS_RST) |-> cc_reg == ISP_CC_RESET)
        else $error("condition register reset value wrong");
    // non-maskable entry forces level 3 whatever the field says
    AST_NMI_L3: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        CLK_EN && CPU_REQ.entry_ack && NMI_REQ |=>
        cc_reg[ISP_CC_HI_POS] && cc_reg[ISP_CC_LO_POS])
        else $error("non-maskable entry did not set level 3");
    AST_ENTRY_LOAD: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        CLK_EN && CPU_REQ.entry_ack && !NMI_REQ && win_any |=>
        {cc_reg[ISP_CC_HI_POS], cc_reg[ISP_CC_LO_POS]}
        == $past(win_code))
        else $error("entry did not load the vector level");
    // a maskable entry must raise the level, never hold or lower it
    AST_WIN_ABOVE: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        CLK_EN && CPU_REQ.entry_ack && !NMI_REQ && win_any |=>
        cur_rank > $past(cur_rank))
        else $error("maskable entry did not raise the level");
    AST_NO_TLI: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        win_any |-> win_vec != 4'h0)
        else $error("top-level field entered arbitration");
    AST_BANK3_TOP: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        bank_reg[3][7:4] == ISP_BANK3_TOP)
        else $error("upper nibble of fourth bank not ones");
    // a refused level-0 field write leaves the old code in place
    AST_NO_L0: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        CLK_EN && wr_fire && wstrb_reg[0] && awaddr_reg == ISP_OFS_BANK0
        && wdata_reg[5:4] == ISP_CODE_L0 |=>
        bank_reg[0][5:4] == $past(bank_reg[0][5:4]))
        else $error("level 0 stored in a field");
    AST_DISABLE: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        CLK_EN && CPU_REQ.disable_irq && !CPU_REQ.restore
        && !CPU_REQ.entry_ack |=> cur_rank == 3'h3)
        else $error("disable did not reach level 3");
    AST_NMI_OFFER: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        CLK_EN && NMI_REQ |=> CPU_ANS.take && CPU_ANS.nmi)
        else $error("non-maskable request not offered");
    // main scenarios worth seeing at least once
    COV_ENTRY: cover property (@(posedge REF_CLK)
        CPU_REQ.entry_ack && win_any);
    COV_NMI_L3: cover property (@(posedge REF_CLK)
        NMI_REQ && cur_rank == 3'h3);
    COV_WRITE: cover property (@(posedge REF_CLK) wr_fire && wr_ok);
    COV_FREEZE: cover property (@(posedge REF_CLK)
        !CLK_EN && CPU_REQ.disable_irq);

endmodule

// [tb/isp_cpu_model.sv]
// cpu sequencer model: takes each offered entry after ack_wait cycles
// and records it. assumes one REF_CLK domain with the priority logic.
`timescale 1ns/1ps
module isp_cpu_model
    import isp_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // pacing from the bench
    input  wire logic [2:0] ack_wait,
    // offer from the priority logic
    input  isp_cpu_ans_t    ans,
    // acknowledge and record
    output logic            entry_ack,
    output logic [7:0]      entry_cnt,
    output logic [4:0]      last_ent
);
    logic [2:0] wait_reg;
    logic [2:0] hold_reg;

    // hold off after an ack so the one-cycle-late offer cannot be taken
    // twice; a real entry sequence is busy for longer than that anyway
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            entry_ack <= 1'b0;
            entry_cnt <= 8'h00;
            last_ent  <= 5'h00;
            wait_reg  <= 3'h0;
            hold_reg  <= 3'h0;
        end
        else
        begin
            entry_ack <= 1'b0;
            if (hold_reg != 3'h0)
                hold_reg <= hold_reg - 3'h1;
            else if (ans.take && wait_reg >= ack_wait)
            begin
                entry_ack <= 1'b1;
                entry_cnt <= entry_cnt + 8'h01;
                last_ent  <= {ans.nmi, ans.nmi ? 4'h0 : ans.vec};
                hold_reg  <= 3'h4;
                wait_reg  <= 3'h0;
            end
            else if (ans.take)
                wait_reg <= wait_reg + 3'h1;
            else
                wait_reg <= 3'h0;
        end
    end
endmodule

// [tb/isp_priority_tb_top.sv]
// bench for the priority logic: axi4-lite register tasks, cpu model,
// pending and non-maskable requests driven on REF_CLK.
`timescale 1ns/1ps
module isp_priority_tb_top;
    import isp_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  op = 3'h0, ack_wait = 3'h0;
    logic [7:0]  rs_val = 8'h00, cond_out, entry_cnt;
    logic [13:0] irq_pend = 14'h0;
    logic        nmi_req = 1'b0, entry_ack;
    logic        clk_en = 1'b1;
    logic [4:0]  last_ent;
    logic [31:0] d;
    isp_cpu_req_t cpu_req;
    isp_cpu_ans_t cpu_ans;
    int          error_cnt = 0, checks = 0, cyc = 0;

    assign cpu_req = {op, rs_val, entry_ack};
    // 100 ns period
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    isp_priority u_isp_priority (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
        .CLK_EN(clk_en), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .CPU_REQ(cpu_req), .CPU_ANS(cpu_ans), .COND_OUT(cond_out),
        .IRQ_PEND(irq_pend), .NMI_REQ(nmi_req));

    isp_cpu_model u_isp_cpu_model (.clk(ref_clk), .rst(sys_rst),
        .ack_wait(ack_wait), .ans(cpu_ans), .entry_ack(entry_ack),
        .entry_cnt(entry_cnt), .last_ent(last_ent));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // values are read at the edge itself, before this edge's updates
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 50);
        chk({31'h0, bvalid}, 32'h00000001);
        r = bresp;
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 50);
        chk({31'h0, rvalid}, 32'h00000001);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // one cycle of enable, disable or restore, then let the level settle
    task automatic cpu_op(input logic [2:0] k, input logic [7:0] v);
        op <= k;
        rs_val <= v;
        @(posedge ref_clk);
        op <= 3'h0;
        repeat (3) @(posedge ref_clk);
    endtask

    // level code from both the register read and the condition output
    task automatic chk_lvl(input logic [1:0] code);
        axi_rd(ISP_OFS_COND);
        chk({30'h0, d[5], d[3]}, {30'h0, code});
        chk({30'h0, cond_out[5], cond_out[3]}, {30'h0, code});
    endtask

    task automatic wait_entry(input logic [4:0] ent);
        logic [7:0] c0 = entry_cnt;
        int n = 0;
        while (entry_cnt === c0 && n < 30)
        begin
            @(posedge ref_clk);
            n++;
        end
        nmi_req <= 1'b0;
        chk({24'h0, entry_cnt}, {24'h0, c0 + 8'h01});
        chk({27'h0, last_ent}, {27'h0, ent});
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic no_entry;
        logic [7:0] c0 = entry_cnt;
        repeat (10) @(posedge ref_clk);
        chk({24'h0, entry_cnt}, {24'h0, c0});
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard well above the few hundred cycles the tests need
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++)
        begin
            axi_rd(8'(4 * i));
            chk(d, 32'h000000FF);
        end
        axi_rd(ISP_OFS_COND);
        chk(d, 32'h000000EA);
        chk({24'h0, cond_out}, 32'h000000EA);
        $display("test reset done");
        axi_wr(ISP_OFS_BANK0, 32'h000000CF);
        axi_wr(ISP_OFS_BANK0, 32'h00000064);
        axi_rd(ISP_OFS_BANK0);
        chk(d, 32'h00000044);
        axi_wr(ISP_OFS_BANK3, 32'h00000000);
        axi_rd(ISP_OFS_BANK3);
        chk(d, 32'h000000F0);
        axi_wr(ISP_OFS_BANK3, 32'h0000000A);
        axi_rd(ISP_OFS_BANK3);
        chk(d, 32'h000000F0);
        axi_wr(8'h18, 32'h00000000);
        chk({30'h0, r}, {30'h0, ISP_RESP_SLVERR});
        axi_rd(8'h18);
        chk({d[29:0], r}, {30'h0, ISP_RESP_SLVERR});
        $display("test banks done");
        axi_wr(ISP_OFS_BANK1, 32'h00000004);
        cpu_op(3'b100, 8'h00);
        chk_lvl(ISP_CODE_L0);
        irq_pend <= 14'h0001;
        no_entry();
        irq_pend <= 14'h0020;
        wait_entry(5'h05);
        chk_lvl(ISP_CODE_L1);
        irq_pend <= 14'h0060;
        wait_entry(5'h06);
        irq_pend <= 14'h00E0;
        no_entry();
        axi_wr(ISP_OFS_BANK1, 32'h00000034);
        wait_entry(5'h06);
        chk_lvl(ISP_CODE_L3);
        $display("test arbitration done");
        irq_pend <= 14'h0000;
        for (int i = 0; i < 2; i++)
        begin
            nmi_req <= 1'b1;
            wait_entry(5'h10);
            chk_lvl(ISP_CODE_L3);
            cpu_op(3'b100, 8'h00);
        end
        ack_wait <= 3'h3;
        irq_pend <= 14'h0090;
        axi_rd(ISP_OFS_STATUS);
        chk(d, 32'h00000140);
        wait_entry(5'h04);
        chk_lvl(ISP_CODE_L2);
        irq_pend <= 14'h0000;
        $display("test entry done");
        // a frozen clock enable and a condition register write
        // must both leave the level alone
        clk_en <= 1'b0;
        cpu_op(3'b010, 8'h00);
        clk_en <= 1'b1;
        chk_lvl(ISP_CODE_L2);
        axi_wr(ISP_OFS_COND, 32'h00000000);
        chk({30'h0, r}, {30'h0, ISP_RESP_OKAY});
        chk_lvl(ISP_CODE_L2);
        cpu_op(3'b010, 8'h00);
        chk_lvl(ISP_CODE_L3);
        cpu_op(3'b001, 8'h00);
        axi_rd(ISP_OFS_COND);
        chk(d, 32'h000000C0);
        cpu_op(3'b101, 8'h08);
        axi_rd(ISP_OFS_COND);
        chk(d, 32'h000000C8);
        $display("test instructions done");
        print_verdict();
    end
endmodule
